// *** inc/mts_pkg.sv ***
// constants, register map and state layout of the transmit sequencer
package mts_pkg;

  localparam logic [4:0] REG_CTRL1 = 5'h00;
  localparam logic [4:0] REG_CTRL2 = 5'h01;
  localparam logic [4:0] REG_IRQ_EN = 5'h02;
  localparam logic [4:0] REG_IRQ_FLAG = 5'h03;
  localparam logic [4:0] REG_TX_START = 5'h04;
  localparam logic [4:0] REG_TX_LEN = 5'h05;
  localparam logic [4:0] REG_RX_START = 5'h06;
  localparam logic [4:0] REG_STATION0 = 5'h07;
  localparam logic [4:0] REG_STATION1 = 5'h08;
  localparam logic [4:0] REG_STATION2 = 5'h09;
  localparam logic [4:0] REG_MAC_CFG = 5'h0A;
  localparam logic [4:0] REG_TX_STATUS = 5'h0B;
  localparam logic [4:0] REG_WIRE_CNT = 5'h0C;

  localparam int CTRL1_TX_REQ_BIT = 1;
  localparam int CTRL2_SA_INS_BIT = 13;
  localparam int IE_GLOBAL_BIT = 15;
  localparam int IE_DONE_BIT = 3;
  localparam int IE_ABORT_BIT = 2;
  localparam int FLAG_DONE_BIT = 3;
  localparam int FLAG_ABORT_BIT = 2;
  localparam int CFG_FULL_DUP_BIT = 0;
  localparam int CFG_AUTO_FCS_BIT = 4;
  localparam int CFG_PAD_LO = 5;
  localparam int ST_LATE_BIT = 10;
  localparam int ST_RETRY_LIMIT_FLAG_BIT = 9;
  localparam int ST_EXCESS_DEFERRAL_FLAG_BIT = 8;
  localparam int ST_DEFERRED_FLAG_BIT = 7;
  localparam int ST_CRC_MISMATCH_FLAG_BIT = 4;
  localparam int ST_COL_LO = 0;

  localparam logic [2:0] PAD_SEL_RST = 3'h5;
  localparam logic AUTO_FCS_RST = 1'b1;
  localparam logic [15:0] GP_START = 16'h0000;
  localparam logic [15:0] MEM_LAST_DEF = 16'h5FFF;
  localparam logic [15:0] MIN_TX_LEN = 16'h0007;
  localparam logic [2:0] ADDR_BYTES = 3'h6;
  localparam logic [15:0] MIN_FRAME_NO_FCS = 16'h003C;
  localparam logic [15:0] LATE_COL_BYTES = 16'h0040;
  localparam logic [2:0] JAM_BYTES = 3'h4;
  localparam logic [7:0] JAM_BYTE = 8'hAA;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam int unsigned MAX_RETRIES_DEF = 15;

  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SLOT_TIME_NS = 5120;
  localparam int unsigned SLOT_CYC = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EXCESS_DEFERRED_FLAG_NS = 242880;
  localparam int unsigned EXCESS_DEFERRED_FLAG_CYC_DEF = EXCESS_DEFERRED_FLAG_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEFERRED_FLAG = 3'h1,
    ST_DATA = 3'h3,
    ST_SRCADDR = 3'h2,
    ST_PAD = 3'h6,
    ST_FCS = 3'h7,
    ST_JAM = 3'h5,
    ST_BACKOFF = 3'h4
  } mts_state_e;

  typedef struct packed {
    mts_state_e st;
    logic tx_req;
    logic sa_ins;
    logic ie_global;
    logic ie_done;
    logic ie_abort;
    logic fl_done;
    logic fl_abort;
    logic [15:0] tx_start;
    logic [15:0] tx_len;
    logic [15:0] rx_start;
    logic [47:0] station;
    logic full_dup;
    logic auto_fcs;
    logic [2:0] pad_sel;
    logic [15:0] status;
    logic [15:0] wire_cnt;
    logic [15:0] rd_ptr;
    logic [15:0] rd_left;
    logic [2:0] hdr_cnt;
    logic [15:0] frame_cnt;
    logic [15:0] live_wire;
    logic [31:0] crc;
    logic crc_add;
    logic [3:0] col_cnt;
    logic deferred;
    logic aborting;
    logic fail_late;
    logic fail_max;
    logic fail_def;
    logic [15:0] cnt;
    logic [9:0] slots;
    logic [7:0] out_byte;
    logic out_valid;
    logic out_last;
    logic [15:0] rdata;
    logic irq;
    logic [15:0] lfsr;
  } mts_core_s;

  localparam mts_core_s CORE_RST = '{
    st: ST_IDLE,
    auto_fcs: AUTO_FCS_RST,
    pad_sel: PAD_SEL_RST,
    crc: CRC_INIT,
    lfsr: LFSR_SEED,
    default: '0
  };

endpackage : mts_pkg

// *** src/mts_crc_byte.sv ***
// one byte step of the reflected ethernet crc-32
`timescale 1ns/1ps
`default_nettype none

module mts_crc_byte
  import mts_pkg::*;
(
  input wire logic [31:0] crc_in,
  input wire logic [7:0] data,
  output logic [31:0] crc_out
);

  logic [31:0] chain [0:8];

  assign chain[0] = crc_in;

  // bits enter lsb first, as they go on the wire
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      assign chain[i+1] = (chain[i][0] ^ data[i]) ?
                          ((chain[i] >> 1) ^ CRC_POLY) : (chain[i] >> 1);
    end
  endgenerate

  assign crc_out = chain[8];

endmodule : mts_crc_byte

`default_nettype wire

// *** src/mts_tx_core.sv ***
// transmit sequencer of the mac: frame build, retries and per-packet status
//
// Behaviour
// R01 - host keeps pointer, length, insertion steady
// R02 - host keeps receive region start steady
// R03 - host enables, clears flags, then global enable
// R04 - host loads buffer, pointer, length, then requests
// R05 - completion clears request, raises done flag
// R06 - start pointer and length stay untouched
// R07 - repeated request resends the same packet
// R08 - status and wire count latched per transmission
// R09 - host reads status only with request clear
// R10 - late, retry and deferral failure flags
// R11 - failure sets flag and drops request
// R12 - crc mismatch flag when software appends crc
// R13 - deferred flag when transmit had to wait
// R14 - four-bit collision tally in status
// R15 - wire count holds bytes actually sent
// R16 - full duplex count includes pad and crc
// R17 - half duplex count adds retry bytes
// R18 - padding and auto crc on after reset
// R19 - insertion enable adds station source address
// R20 - request starts; host clear aborts, with jam only while sending; a clear during a collision jam does not abort and the frame is retried
// R21 - read wraps at region ends
// R22 - length counts only fetched bytes
// R23 - request refused for length seven or less
`timescale 1ns/1ps
`default_nettype none

module mts_tx_core
  import mts_pkg::*;
#(
  parameter logic [15:0] MEM_LAST = MEM_LAST_DEF,
  parameter int unsigned MAX_RETRIES = MAX_RETRIES_DEF,
  parameter int unsigned EXCESS_DEFERRED_FLAG_CYC = EXCESS_DEFERRED_FLAG_CYC_DEF
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic [15:0] mem_addr,
  input wire logic [7:0] mem_rd_data,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_last,
  input wire logic tx_ready,
  input wire logic carrier_sense,
  input wire logic collision,
  input wire logic pause_hold,
  output logic irq
);

  generate
    if (MAX_RETRIES > 15) begin : g_bad_retries
      $error("MAX_RETRIES must fit the four-bit collision tally");
    end
    if (EXCESS_DEFERRED_FLAG_CYC < 1 || EXCESS_DEFERRED_FLAG_CYC > 65535) begin : g_bad_deferred_flag
      $error("EXCESS_DEFERRED_FLAG_CYC must lie in 1..65535");
    end
  endgenerate

  mts_core_s q;
  mts_core_s d;

  logic [31:0] crc_next;
  logic [31:0] crc_cur;
  logic [31:0] fcs_val;
  logic ld;
  logic emit;
  logic covered;
  logic last_v;
  logic [7:0] byte_v;
  logic tail_next;
  logic finish;
  logic restart;
  logic host_clear;
  logic busy_med;
  logic coll;
  logic sending;
  logic pad_on;
  logic [3:0] bo_exp;

  mts_crc_byte u_crc (
    .crc_in (q.crc),
    .data (q.out_byte),
    .crc_out (crc_next)
  );

  // the gp region ends just below the receive region, which ends at the top
  function automatic logic [15:0] next_ptr(input logic [15:0] p, input logic [15:0] rxs);
    if (p == rxs - 16'h0001) begin
      next_ptr = GP_START;
    end else if (p == MEM_LAST) begin
      next_ptr = rxs;
    end else begin
      next_ptr = p + 16'h0001;
    end
  endfunction : next_ptr

  always_comb begin
    d = q;
    emit = 1'b0;
    covered = 1'b0;
    last_v = 1'b0;
    byte_v = PAD_BYTE;
    tail_next = 1'b0;
    finish = 1'b0;
    restart = 1'b0;
    bo_exp = 4'h0;
    ld = !q.out_valid || tx_ready;
    busy_med = pause_hold || (!q.full_dup && carrier_sense);
    coll = collision && !q.full_dup;
    sending = (q.st == ST_DATA) || (q.st == ST_SRCADDR) || (q.st == ST_PAD) ||
              (q.st == ST_FCS);
    pad_on = q.auto_fcs && (q.pad_sel != 3'h0);
    host_clear = reg_wr && (reg_addr == REG_CTRL1) &&
                 !reg_wdata[CTRL1_TX_REQ_BIT] && q.tx_req;
    crc_cur = q.crc_add ? crc_next : q.crc;
    fcs_val = ~crc_cur;

    if (q.out_valid && tx_ready) begin
      d.out_valid = 1'b0;
    end
    d.crc_add = 1'b0;
    if (q.crc_add) begin
      d.crc = crc_next;
    end
    d.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};

    // register writes come first so that hardware updates below win
    if (reg_wr) begin
      if (reg_addr == REG_CTRL1) begin
        if (!reg_wdata[CTRL1_TX_REQ_BIT]) begin
          d.tx_req = 1'b0; // R20
        end else if (q.tx_len > MIN_TX_LEN) begin
          d.tx_req = 1'b1; // R23
        end
      end else if (reg_addr == REG_CTRL2) begin
        d.sa_ins = reg_wdata[CTRL2_SA_INS_BIT];
      end else if (reg_addr == REG_IRQ_EN) begin
        d.ie_global = reg_wdata[IE_GLOBAL_BIT];
        d.ie_done = reg_wdata[IE_DONE_BIT];
        d.ie_abort = reg_wdata[IE_ABORT_BIT];
      end else if (reg_addr == REG_IRQ_FLAG) begin
        d.fl_done = reg_wdata[FLAG_DONE_BIT];
        d.fl_abort = reg_wdata[FLAG_ABORT_BIT];
      end else if (reg_addr == REG_TX_START) begin
        d.tx_start = reg_wdata;
      end else if (reg_addr == REG_TX_LEN) begin
        d.tx_len = reg_wdata;
      end else if (reg_addr == REG_RX_START) begin
        d.rx_start = reg_wdata;
      end else if (reg_addr == REG_STATION0) begin
        d.station[15:0] = reg_wdata;
      end else if (reg_addr == REG_STATION1) begin
        d.station[31:16] = reg_wdata;
      end else if (reg_addr == REG_STATION2) begin
        d.station[47:32] = reg_wdata;
      end else if (reg_addr == REG_MAC_CFG) begin
        d.full_dup = reg_wdata[CFG_FULL_DUP_BIT];
        d.auto_fcs = reg_wdata[CFG_AUTO_FCS_BIT];
        d.pad_sel = reg_wdata[CFG_PAD_LO +: 3];
      end
    end

    if (sending && (host_clear || coll)) begin
      d.st = ST_JAM; // R20
      d.cnt = 16'h0000;
      if (host_clear) begin
        d.aborting = 1'b1;
      end else begin
        if (q.col_cnt != 4'hF) begin
          d.col_cnt = q.col_cnt + 4'h1; // R14
        end
        if (q.frame_cnt >= LATE_COL_BYTES) begin
          d.fail_late = 1'b1; // R10
        end else if (q.col_cnt == 4'(MAX_RETRIES)) begin
          d.fail_max = 1'b1; // R10
        end
      end
    end else begin
      case (q.st)
        ST_IDLE: begin
          if (q.tx_req) begin
            // a fresh copy of pointer and length; the programmed ones stay put
            restart = 1'b1; // R06 R07
            d.col_cnt = 4'h0;
            d.deferred = 1'b0;
            d.aborting = 1'b0;
            d.fail_late = 1'b0;
            d.fail_max = 1'b0;
            d.fail_def = 1'b0;
            d.live_wire = 16'h0000;
          end
        end
        ST_DEFERRED_FLAG: begin
          if (host_clear) begin
            d.aborting = 1'b1;
            finish = 1'b1;
          end else if (busy_med) begin
            d.deferred = 1'b1; // R13
            d.cnt = q.cnt + 16'h0001;
            if (!q.full_dup && (q.cnt == 16'(EXCESS_DEFERRED_FLAG_CYC - 1))) begin
              d.fail_def = 1'b1; // R10 R11
              finish = 1'b1;
            end
          end else begin
            d.st = ST_DATA;
          end
        end
        ST_DATA: begin
          if (ld) begin
            emit = 1'b1;
            covered = 1'b1;
            byte_v = mem_rd_data;
            d.rd_ptr = next_ptr(q.rd_ptr, q.rx_start); // R21
            d.rd_left = q.rd_left - 16'h0001; // R22
            if (q.hdr_cnt != ADDR_BYTES) begin
              d.hdr_cnt = q.hdr_cnt + 3'h1;
            end
            if (q.rd_left == 16'h0001) begin
              tail_next = 1'b1;
            end else if (q.sa_ins && (q.hdr_cnt == ADDR_BYTES - 3'h1)) begin
              d.st = ST_SRCADDR; // R19
              d.cnt = 16'h0000;
            end
          end
        end
        ST_SRCADDR: begin
          if (ld) begin
            emit = 1'b1;
            covered = 1'b1;
            byte_v = q.station[{q.cnt[2:0], 3'h0} +: 8]; // R19
            d.cnt = q.cnt + 16'h0001;
            if (q.cnt[2:0] == ADDR_BYTES - 3'h1) begin
              d.st = ST_DATA;
            end
          end
        end
        ST_PAD: begin
          if (ld) begin
            emit = 1'b1;
            covered = 1'b1;
            byte_v = PAD_BYTE;
            tail_next = 1'b1;
          end
        end
        ST_FCS: begin
          if (!q.auto_fcs) begin
            // software crc already went out; the residue shows whether it was right
            d.status[ST_CRC_MISMATCH_FLAG_BIT] = (crc_cur != CRC_RESIDUE); // R12
            finish = 1'b1;
          end else if (ld) begin
            emit = 1'b1;
            byte_v = fcs_val[{q.cnt[1:0], 3'h0} +: 8];
            d.cnt = q.cnt + 16'h0001;
            if (q.cnt[1:0] == 2'h3) begin
              last_v = 1'b1;
              finish = 1'b1;
            end
          end
        end
        ST_JAM: begin
          if (ld) begin
            emit = 1'b1;
            byte_v = JAM_BYTE;
            d.cnt = q.cnt + 16'h0001;
            if (q.cnt[2:0] == JAM_BYTES - 3'h1) begin
              last_v = 1'b1;
              if (q.aborting || q.fail_late || q.fail_max) begin
                finish = 1'b1; // R11
              end else begin
                // truncated binary exponential backoff, capped at ten doublings
                bo_exp = (q.col_cnt > 4'hA) ? 4'hA : q.col_cnt;
                d.slots = q.lfsr[9:0] & (10'h3FF >> (4'hA - bo_exp));
                d.cnt = 16'h0000;
                d.st = ST_BACKOFF;
              end
            end
          end
        end
        ST_BACKOFF: begin
          if (host_clear) begin
            d.aborting = 1'b1;
            finish = 1'b1;
          end else if (q.slots == 10'h000) begin
            restart = 1'b1; // R17
          end else if (q.cnt == 16'(SLOT_CYC - 1)) begin
            d.cnt = 16'h0000;
            d.slots = q.slots - 10'h001;
          end else begin
            d.cnt = q.cnt + 16'h0001;
          end
        end
        default: begin
          d.st = ST_IDLE;
        end
      endcase
    end

    if (tail_next) begin
      if (pad_on && (q.frame_cnt + 16'h0001 < MIN_FRAME_NO_FCS)) begin
        d.st = ST_PAD;
      end else begin
        d.st = ST_FCS; // R16
        d.cnt = 16'h0000;
      end
    end

    if (restart) begin
      d.st = ST_DEFERRED_FLAG;
      d.rd_ptr = q.tx_start;
      d.rd_left = q.tx_len;
      d.hdr_cnt = 3'h0;
      d.frame_cnt = 16'h0000;
      d.crc = CRC_INIT;
      d.crc_add = 1'b0;
      d.cnt = 16'h0000;
    end

    if (emit) begin
      d.out_byte = byte_v;
      d.out_valid = 1'b1;
      d.out_last = last_v;
      d.live_wire = q.live_wire + 16'h0001; // R15 R16 R17
      if (q.st != ST_JAM) begin
        d.frame_cnt = q.frame_cnt + 16'h0001;
      end
      d.crc_add = covered;
    end

    if (finish) begin
      d.st = ST_IDLE;
      d.tx_req = 1'b0; // R05 R11
      d.wire_cnt = d.live_wire; // R08
      d.status[ST_LATE_BIT] = d.fail_late; // R10
      d.status[ST_RETRY_LIMIT_FLAG_BIT] = d.fail_max;
      d.status[ST_EXCESS_DEFERRAL_FLAG_BIT] = d.fail_def;
      d.status[ST_DEFERRED_FLAG_BIT] = d.deferred; // R13
      d.status[ST_COL_LO +: 4] = d.col_cnt; // R14
      if (q.st != ST_FCS || q.auto_fcs) begin
        d.status[ST_CRC_MISMATCH_FLAG_BIT] = 1'b0;
      end
      if (d.fail_late || d.fail_max || d.fail_def || d.aborting) begin
        d.fl_abort = 1'b1;
      end else begin
        d.fl_done = 1'b1; // R05
      end
    end

    d.irq = q.ie_global && ((q.fl_done && q.ie_done) || (q.fl_abort && q.ie_abort));

    if (reg_addr == REG_CTRL1) begin
      d.rdata = 16'(q.tx_req) << CTRL1_TX_REQ_BIT;
    end else if (reg_addr == REG_CTRL2) begin
      d.rdata = 16'(q.sa_ins) << CTRL2_SA_INS_BIT;
    end else if (reg_addr == REG_IRQ_EN) begin
      d.rdata = (16'(q.ie_global) << IE_GLOBAL_BIT) | (16'(q.ie_done) << IE_DONE_BIT) |
                (16'(q.ie_abort) << IE_ABORT_BIT);
    end else if (reg_addr == REG_IRQ_FLAG) begin
      d.rdata = (16'(q.fl_done) << FLAG_DONE_BIT) | (16'(q.fl_abort) << FLAG_ABORT_BIT);
    end else if (reg_addr == REG_TX_START) begin
      d.rdata = q.tx_start;
    end else if (reg_addr == REG_TX_LEN) begin
      d.rdata = q.tx_len;
    end else if (reg_addr == REG_RX_START) begin
      d.rdata = q.rx_start;
    end else if (reg_addr == REG_STATION0) begin
      d.rdata = q.station[15:0];
    end else if (reg_addr == REG_STATION1) begin
      d.rdata = q.station[31:16];
    end else if (reg_addr == REG_STATION2) begin
      d.rdata = q.station[47:32];
    end else if (reg_addr == REG_MAC_CFG) begin
      d.rdata = (16'(q.full_dup) << CFG_FULL_DUP_BIT) | (16'(q.auto_fcs) << CFG_AUTO_FCS_BIT) |
                (16'(q.pad_sel) << CFG_PAD_LO);
    end else if (reg_addr == REG_TX_STATUS) begin
      d.rdata = q.status;
    end else if (reg_addr == REG_WIRE_CNT) begin
      d.rdata = q.wire_cnt;
    end else begin
      d.rdata = 16'h0000;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q <= CORE_RST; // R18
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign mem_addr = q.rd_ptr;
  assign tx_data = q.out_byte;
  assign tx_valid = q.out_valid;
  assign tx_last = q.out_last;
  assign irq = q.irq;

endmodule : mts_tx_core

`default_nettype wire

// *** dv/mts_tx_core_asserts.sv ***
// port-level assertions of the transmit sequencer
`timescale 1ns/1ps
`default_nettype none
module mts_tx_core_asserts
  import mts_pkg::*;
#(
  parameter logic [15:0] MEM_LAST = MEM_LAST_DEF
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic tx_ready,
  input wire logic carrier_sense,
  input wire logic pause_hold,
  input wire logic irq
);
  // shadows of host-written registers, taken on the same write edge as the design
  logic [15:0] len_q;
  logic [15:0] txs_q;
  logic [15:0] rxs_q;
  logic glob_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      len_q <= '0;
      txs_q <= '0;
      rxs_q <= '0;
      glob_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == REG_TX_LEN) len_q <= reg_wdata;
      if (reg_addr == REG_TX_START) txs_q <= reg_wdata;
      if (reg_addr == REG_RX_START) rxs_q <= reg_wdata;
      if (reg_addr == REG_IRQ_EN) glob_q <= reg_wdata[IE_GLOBAL_BIT];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence start_s;
    reg_wr && reg_addr == REG_CTRL1 && reg_wdata[CTRL1_TX_REQ_BIT] && !tx_valid;
  endsequence
  sequence quiet_s;
    (!pause_hold && !carrier_sense) [*2];
  endsequence
  sequence start_rd_s;
    reg_wr && reg_addr == REG_TX_START ##1 !reg_wr && reg_addr == REG_TX_START;
  endsequence
  valid_hold_a: assert property (tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("tx byte dropped early");
  reset_quiet_a: assert property ($rose(rst_b)
    |-> !tx_valid && !irq && reg_rdata == 16'h0000) else $error("outputs busy after reset");
  refuse_a: assert property (start_s ##0 len_q <= MIN_TX_LEN
    |=> (!tx_valid) [*4]) else $error("short length was sent");
  start_a: assert property (start_s ##0 len_q > MIN_TX_LEN ##1 quiet_s
    |-> ##[0:3] tx_valid) else $error("request did not start a frame");
  pause_a: assert property ((!tx_valid && pause_hold) [*2]
    |=> !tx_valid) else $error("frame started under hold");
  keep_ptr_a: assert property (start_rd_s
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("start pointer not kept");
  irq_gate_a: assert property (!glob_q |=> !irq) else $error("irq without global enable");
  wrap_gp_a: assert property ($changed(mem_addr) && $past(mem_addr) == rxs_q - 16'h0001
    |-> mem_addr == GP_START || mem_addr == txs_q) else $error("no wrap to zero");
  wrap_rx_a: assert property ($changed(mem_addr) && $past(mem_addr) == MEM_LAST
    |-> mem_addr == rxs_q || mem_addr == txs_q) else $error("no wrap to receive start");
endmodule : mts_tx_core_asserts
`default_nettype wire

// *** dv/mts_far_model.sv ***
// buffer memory and wire sink facing the transmit sequencer
`timescale 1ns/1ps
`default_nettype none
module mts_far_model
  import mts_pkg::*;
(
  input wire logic clock,
  input wire logic [15:0] mem_addr,
  output logic [7:0] mem_rd_data,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic stall_en,
  input wire logic clr
);
  logic [7:0] cap [0:1023];
  int n_cap = 0;
  // memory content is a pure function of address so no preload is needed
  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : mem_byte
  assign mem_rd_data = mem_byte(mem_addr);
  initial tx_ready = 1'b0;
  always @(negedge clock) tx_ready <= !stall_en || ($urandom_range(2, 0) != 0);
  always @(posedge clock) begin
    if (clr) n_cap <= 0;
    else if (tx_valid && tx_ready) begin
      cap[n_cap % 1024] <= tx_data;
      n_cap <= n_cap + 1;
    end
  end
endmodule : mts_far_model
`default_nettype wire

// *** dv/mts_tx_core_tb_top.sv ***
// self-checking bench of the transmit sequencer
`timescale 1ns/1ps
`default_nettype none
module mts_tx_core_tb_top
  import mts_pkg::*;
  ;
  localparam logic [15:0] RX_ADDR = 16'h0100;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] reg_addr = '0;
  logic reg_wr = 1'b0;
  logic [15:0] reg_wdata = '0;
  logic [15:0] reg_rdata, mem_addr, v, st, ln;
  logic [7:0] mem_rd_data, tx_data;
  logic tx_valid, tx_last, tx_ready, irq;
  logic carrier_sense = 1'b0;
  logic collision = 1'b0;
  logic pause_hold = 1'b0;
  logic stall_en = 1'b0;
  logic clr = 1'b0;
  logic col_all = 1'b0;
  logic pad_en = 1'b1;
  logic last_seen = 1'b0;
  logic exp_last = 1'b0;
  int col_at = -1;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [7:0] sta [6];
  logic [7:0] exp_q [$];
  always #20 clock = ~clock;
  always @(negedge clock) collision <= (col_all && tx_valid) || (i_far.n_cap == col_at);
  // frame end marker of the last byte the sink took
  always @(posedge clock) if (tx_valid && tx_ready) last_seen <= tx_last;
  mts_tx_core #(.MAX_RETRIES(2), .EXCESS_DEFERRED_FLAG_CYC(20)) i_dut (.clock(clock), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .mem_addr(mem_addr), .mem_rd_data(mem_rd_data), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .carrier_sense(carrier_sense),
    .collision(collision), .pause_hold(pause_hold), .irq(irq));
  mts_far_model i_far (.clock(clock), .mem_addr(mem_addr), .mem_rd_data(mem_rd_data),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .stall_en(stall_en), .clr(clr));
  task automatic summarize();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    @(negedge clock);
    reg_addr = a;
    @(negedge clock);
    chk(reg_rdata, e);
  endtask : rchk
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
    c = c ^ {24'h000000, b};
    for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    return c;
  endfunction : crc_step
  task automatic kick();
    @(negedge clock);
    clr = 1'b1;
    @(negedge clock);
    clr = 1'b0;
    wr(REG_CTRL1, 16'h0002);
  endtask : kick
  // expected wire bytes: fetch with wraps, station after byte six, pad, inverted crc
  task automatic go(input logic [15:0] s, input logic [15:0] n, input logic ins, input logic fcs);
    logic [15:0] a;
    logic [31:0] c;
    a = s;
    c = CRC_INIT;
    exp_last = fcs;
    exp_q.delete();
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(i_far.mem_byte(a));
      if (ins && i == 5) for (int k = 0; k < 6; k++) exp_q.push_back(sta[k]);
      a = (a == RX_ADDR - 16'h0001) ? GP_START : (a == MEM_LAST_DEF) ? RX_ADDR : a + 16'h0001;
    end
    while (fcs && pad_en && exp_q.size() < MIN_FRAME_NO_FCS) exp_q.push_back(PAD_BYTE);
    foreach (exp_q[i]) c = crc_step(c, exp_q[i]);
    if (fcs) for (int k = 0; k < 4; k++) exp_q.push_back(~c[8*k +: 8]);
    wr(REG_CTRL2, {2'b00, ins, 13'h0000});
    wr(REG_TX_START, s);
    wr(REG_TX_LEN, n);
    kick();
  endtask : go
  task automatic post(input logic [15:0] stat, input logic [15:0] flag);
    int b;
    v = 16'hFFFF;
    for (int i = 0; i < 3000 && (v[1] !== 1'b0 || tx_valid !== 1'b0); i++) begin
      @(negedge clock);
      reg_addr = REG_CTRL1;
      @(negedge clock);
      v = reg_rdata;
    end
    chk({14'h0000, v[1], tx_valid}, 16'h0000);
    b = i_far.n_cap - exp_q.size();
    rchk(REG_TX_STATUS, stat);
    rchk(REG_WIRE_CNT, 16'(i_far.n_cap));
    rchk(REG_IRQ_FLAG, flag);
    chk({15'h0000, irq}, 16'h0001);
    chk({15'h0000, last_seen}, {15'h0000, exp_last});
    foreach (exp_q[i]) chk({8'h00, i_far.cap[b + i]}, {8'h00, exp_q[i]});
    wr(REG_IRQ_FLAG, 16'h0000);
  endtask : post
  task automatic jam_exp();
    exp_q = {JAM_BYTE, JAM_BYTE, JAM_BYTE, JAM_BYTE};
    exp_last = 1'b1;
  endtask : jam_exp
  initial begin
    #2000000;
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    v = 16'($urandom(32'h2AC600E6));
    repeat (16) @(posedge clock);
    @(negedge clock);
    rst_b = 1'b1;
    rchk(REG_MAC_CFG, 16'h00B0);
    rchk(REG_TX_STATUS, 16'h0000);
    rchk(5'h1F, 16'h0000);
    for (int k = 0; k < 6; k++) sta[k] = 8'($urandom);
    for (int k = 0; k < 3; k++) wr(REG_STATION0 + 5'(k), {sta[2*k+1], sta[2*k]});
    wr(REG_RX_START, RX_ADDR);
    wr(REG_IRQ_EN, 16'h800C);
    wr(REG_IRQ_FLAG, 16'h0000);
    wr(REG_MAC_CFG, 16'h00B1);
    // first two frames cross the general and receive region ends, third is the shortest legal
    for (int n = 0; n < 6; n++) begin
      stall_en = n[0];
      ln = (n == 2) ? 16'h0008 : 16'($urandom_range(70, 8));
      st = (n == 1) ? 16'h5FFC : (n == 0) ? 16'h00FC : 16'($urandom_range(255, 0));
      go(st, ln, n[1], 1'b1);
      post(16'h0000, 16'h0008);
      chk(16'(i_far.n_cap), 16'(exp_q.size()));
      rchk(REG_TX_START, st);
      rchk(REG_TX_LEN, ln);
    end
    kick();
    post(16'h0000, 16'h0008);
    wr(REG_TX_LEN, 16'h0007);
    wr(REG_CTRL1, 16'h0002);
    rchk(REG_CTRL1, 16'h0000);
    // pad select zero with auto crc: short frame goes out unpadded
    pad_en = 1'b0;
    wr(REG_MAC_CFG, 16'h0011);
    go(16'h0080, 16'h0010, 1'b0, 1'b1);
    post(16'h0000, 16'h0008);
    pad_en = 1'b1;
    wr(REG_MAC_CFG, 16'h0001);
    go(16'h0040, 16'h0014, 1'b0, 1'b0);
    post(16'h0010, 16'h0008);
    wr(REG_MAC_CFG, 16'h00B1);
    pause_hold = 1'b1;
    fork
      begin
        repeat (20) @(negedge clock);
        pause_hold = 1'b0;
      end
    join_none
    go(16'h0200, 16'h0030, 1'b1, 1'b1);
    post(16'h0080, 16'h0008);
    wr(REG_MAC_CFG, 16'h00B0);
    go(16'h0300, 16'h0028, 1'b0, 1'b1);
    col_at = 10;
    post(16'h0001, 16'h0008);
    go(16'h0300, 16'h0046, 1'b0, 1'b1);
    col_at = 66;
    jam_exp();
    post(16'h0401, 16'h0004);
    col_at = -1;
    col_all = 1'b1;
    go(16'h0300, 16'h0028, 1'b0, 1'b1);
    jam_exp();
    post(16'h0203, 16'h0004);
    col_all = 1'b0;
    carrier_sense = 1'b1;
    go(16'h0300, 16'h0028, 1'b0, 1'b1);
    exp_q.delete();
    post(16'h0180, 16'h0004);
    carrier_sense = 1'b0;
    wr(REG_MAC_CFG, 16'h00B1);
    go(16'h0300, 16'h0046, 1'b0, 1'b1);
    for (int i = 0; i < 400 && i_far.n_cap < 12; i++) @(negedge clock);
    wr(REG_CTRL1, 16'h0000);
    jam_exp();
    post(16'h0000, 16'h0004);
    summarize();
  end
endmodule : mts_tx_core_tb_top
bind mts_tx_core mts_tx_core_asserts #(.MEM_LAST(MEM_LAST)) i_chk (.clock(clock), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .mem_addr(mem_addr), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
  .tx_ready(tx_ready), .carrier_sense(carrier_sense), .pause_hold(pause_hold), .irq(irq));
`default_nettype wire
